// ### common/tcgj_defs.vh
// Notes on behaviour
// R1: Drop-frame skips frame counts 0 and 1 each minute, except minutes divisible by ten.
// R2: Drop-frame flag in generated code is set exactly while counting drop-frame.
// R3: With drop frame off, every frame number is counted with no skips.
// R4: Continuous jam takes the drop-frame setting from the incoming code.
// R5: The 625-line standard never counts drop-frame, whatever is selected.
// R6: Continuous jam, 525-line, reader in IRIG day format forces drop-frame on.
// R7: Operator should select drop-frame for time-date or conversion on 525 lines.
// R8: Operator should select drop-frame in momentary jam with IRIG day reader.
// R9: Conversion jams hours, minutes, seconds and frames on a resync; frames then run at the output rate.
// R10: Jam adds offset to reader time modulo 24 hours; zero offset jams exactly. Code moves a jam that lands on a drop-frame skipped count to frame 2.
// R11: 30-to-25 input must be drop-frame; 25-to-30 needs drop-frame selected.
// R12: Conversion resyncs when hours, minutes or seconds differ, or when frame difference exceeds the window, default 6.
// R13: Inserter off passes video unchanged; on adds VITC to program video.
// R14: SMPTE VITC goes on a selectable line, separate for 525 and 625, default 10.
// R15: IRIG VITC goes on its own selectable line, separate per standard.
// R16: User should keep VITC lines between 10 (6 for PAL) and 32.
// R17: User should keep SMPTE and IRIG VITC lines non-adjacent.
// R18: DST end steps from end of 01:59:59 back to 01:00:00, repeating that hour.
// R19: Two-field framing needs no external colour reference.
// R20: DST start jumps from 01:59:59 straight to 03:00:00.
// R21: Counter rolls from the last frame of 23:59:59 to 00:00:00:00.
`ifndef TCGJ_DEFS_VH
`define TCGJ_DEFS_VH

`define TCGJ_MODE_FREE      2'h0
`define TCGJ_MODE_MOMENT    2'h1
`define TCGJ_MODE_CONT      2'h2
`define TCGJ_MODE_CONV      2'h3

`define TCGJ_LAST_FRAME_30  5'h1d
`define TCGJ_LAST_FRAME_25  5'h18
`define TCGJ_LAST_SEC       6'h3b
`define TCGJ_LAST_MIN       6'h3b
`define TCGJ_LAST_HOUR      5'h17
`define TCGJ_DROP_RESUME    5'h02
`define TCGJ_DROP_DECADE    6'h0a
`define TCGJ_JAM_WINDOW     5'h06
`define TCGJ_DEFAULT_LINE   10'h00a

`define TCGJ_DST_HOUR       5'h01
`define TCGJ_DST_SKIP_HOUR  5'h03

`endif

// ### rtl/tcgj_vitc_keyer.v
`timescale 1ns/100ps
`include "tcgj_defs.vh"

module tcgj_vitc_keyer #(
  parameter LINE_W = 10,
  parameter VID_W  = 10
) (
  input  wire              ref_clk_i,
  input  wire              rst_i,
  input  wire              std_625_i,
  input  wire              vitc_on_i,
  input  wire [LINE_W-1:0] smpte_insert_line_525_i,
  input  wire [LINE_W-1:0] smpte_insert_line_625_i,
  input  wire [LINE_W-1:0] irig_line_525_i,
  input  wire [LINE_W-1:0] irig_line_625_i,
  input  wire              vid_valid_i,
  input  wire [LINE_W-1:0] vid_line_i,
  input  wire [VID_W-1:0]  vid_data_i,
  input  wire [VID_W-1:0]  vitc_smpte_data_i,
  input  wire [VID_W-1:0]  vitc_irig_data_i,
  output reg               vid_valid_o,
  output reg  [VID_W-1:0]  vid_data_o
);

  wire [LINE_W-1:0] smpte_line;
  wire [LINE_W-1:0] irig_line;
  reg  [VID_W-1:0]  next_data;

  // Each standard keeps its own pair of line numbers
  assign smpte_line = std_625_i ? smpte_insert_line_625_i : smpte_insert_line_525_i; // [R14]
  assign irig_line  = std_625_i ? irig_line_625_i : irig_line_525_i;                 // [R15]

  // SMPTE wins if both selections land on one line; placing them apart is the user's job
  always @* begin
    next_data = vid_data_i;                                        // [R13]
    if (vitc_on_i && vid_line_i == smpte_line) begin
      next_data = vitc_smpte_data_i;                               // [R14]
    end else if (vitc_on_i && vid_line_i == irig_line) begin
      next_data = vitc_irig_data_i;                                // [R15]
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vid_valid_o <= 1'b0;
      vid_data_o  <= {VID_W{1'b0}};
    end else begin
      vid_valid_o <= vid_valid_i;
      vid_data_o  <= next_data;
    end
  end

endmodule

// ### rtl/tcgj_timecode_jam.v
`timescale 1ns/100ps
`include "tcgj_defs.vh"

module tcgj_timecode_jam #(
  parameter [4:0] JAM_WINDOW = `TCGJ_JAM_WINDOW,
  parameter       LINE_W     = 10,
  parameter       VID_W      = 10
) (
  input  wire              ref_clk_i,
  input  wire              rst_i,
  input  wire              frame_tick_i,
  input  wire              std_625_i,
  input  wire [1:0]        gen_mode_i,
  input  wire              drop_sel_i,
  input  wire              four_field_i,
  input  wire              col_ref_lock_i,
  input  wire              jam_req_i,
  input  wire              rdr_valid_i,
  input  wire [4:0]        rdr_hours_i,
  input  wire [5:0]        rdr_minutes_i,
  input  wire [5:0]        rdr_seconds_i,
  input  wire [4:0]        rdr_frames_i,
  input  wire              rdr_drop_flag_i,
  input  wire              rdr_irig_day_i,
  input  wire [4:0]        jam_offset_value_hours_i,
  input  wire [5:0]        jam_offset_value_minutes_i,
  input  wire [5:0]        jam_offset_value_seconds_i,
  input  wire [4:0]        jam_offset_value_frames_i,
  input  wire              dst_start_arm_i,
  input  wire              dst_end_arm_i,
  input  wire              vitc_on_i,
  input  wire [LINE_W-1:0] smpte_insert_line_525_i,
  input  wire [LINE_W-1:0] smpte_insert_line_625_i,
  input  wire [LINE_W-1:0] irig_line_525_i,
  input  wire [LINE_W-1:0] irig_line_625_i,
  input  wire              vid_valid_i,
  input  wire [LINE_W-1:0] vid_line_i,
  input  wire [VID_W-1:0]  vid_data_i,
  input  wire [VID_W-1:0]  vitc_smpte_data_i,
  input  wire [VID_W-1:0]  vitc_irig_data_i,
  output reg  [4:0]        tc_hours_o,
  output reg  [5:0]        tc_minutes_o,
  output reg  [5:0]        tc_seconds_o,
  output reg  [4:0]        tc_frames_o,
  output reg               tc_drop_flag_o,
  output reg               tc_colour_flag_o,
  output reg               jam_done_o,
  output reg               dst_repeat_o,
  output wire              vid_valid_o,
  output wire [VID_W-1:0]  vid_data_o
);

  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_APPLY = 2'b10;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg        apply_full;
  reg        next_apply_full;
  reg  [4:0] tgt_h;
  reg  [5:0] tgt_m;
  reg  [5:0] tgt_s;
  reg  [4:0] tgt_f;
  reg        dst_start_pend;
  reg        dst_end_pend;

  wire       drop_eff;
  wire [4:0] last_frame;
  wire       minute_decade;

  // Drop-frame choice: 625 overrides all, then continuous jam, then user
  assign drop_eff = std_625_i ? 1'b0 :                               // [R5]
                    (gen_mode_i == `TCGJ_MODE_CONT) ?
                    (rdr_irig_day_i | rdr_drop_flag_i) :            // [R4] [R6]
                    drop_sel_i;                                     // [R3]
  assign last_frame = std_625_i ? `TCGJ_LAST_FRAME_25 : `TCGJ_LAST_FRAME_30;

  // Offset-adjusted reader time, field by field with carries
  reg  [5:0] sum_f;
  reg  [6:0] sum_s;
  reg  [6:0] sum_m;
  reg  [5:0] sum_h;
  reg  [4:0] adj_h;
  reg  [5:0] adj_m;
  reg  [5:0] adj_s;
  reg  [4:0] adj_f;
  reg        c_f;
  reg        c_s;
  reg        c_m;

  always @* begin
    sum_f = {1'b0, rdr_frames_i} + {1'b0, jam_offset_value_frames_i};   // [R10]
    c_f   = (sum_f > {1'b0, last_frame});
    if (c_f) begin
      sum_f = sum_f - ({1'b0, last_frame} + 6'h01);
    end
    if (sum_f > {1'b0, last_frame}) begin
      sum_f = {1'b0, last_frame};
    end
    adj_f = sum_f[4:0];
    sum_s = {1'b0, rdr_seconds_i} + {1'b0, jam_offset_value_seconds_i} + {6'h00, c_f};
    c_s   = (sum_s > {1'b0, `TCGJ_LAST_SEC});
    if (c_s) begin
      sum_s = sum_s - 7'h3c;
    end
    adj_s = sum_s[5:0];
    sum_m = {1'b0, rdr_minutes_i} + {1'b0, jam_offset_value_minutes_i} + {6'h00, c_s};
    c_m   = (sum_m > {1'b0, `TCGJ_LAST_MIN});
    if (c_m) begin
      sum_m = sum_m - 7'h3c;
    end
    adj_m = sum_m[5:0];
    sum_h = {1'b0, rdr_hours_i} + {1'b0, jam_offset_value_hours_i} + {5'h00, c_m};
    if (sum_h > {1'b0, `TCGJ_LAST_HOUR}) begin
      sum_h = sum_h - 6'h18;                                          // [R10]
    end
    adj_h = sum_h[4:0];
    // A jam never lands on a count that drop-frame skips
    if (drop_eff && adj_s == 6'h00 && (adj_m % `TCGJ_DROP_DECADE) != 6'h00 &&
        adj_f < `TCGJ_DROP_RESUME) begin
      adj_f = `TCGJ_DROP_RESUME;                                      // [R1]
    end
  end

  // Free-running increment
  reg  [4:0] inc_h;
  reg  [5:0] inc_m;
  reg  [5:0] inc_s;
  reg  [4:0] inc_f;
  reg        dst_start_hit;
  reg        dst_end_hit;

  always @* begin
    inc_h = tc_hours_o;
    inc_m = tc_minutes_o;
    inc_s = tc_seconds_o;
    inc_f = tc_frames_o + 5'h01;                                      // [R3]
    dst_start_hit = 1'b0;
    dst_end_hit   = 1'b0;
    if (tc_frames_o >= last_frame) begin
      inc_f = 5'h00;
      inc_s = tc_seconds_o + 6'h01;
      if (tc_seconds_o == `TCGJ_LAST_SEC) begin
        inc_s = 6'h00;
        inc_m = tc_minutes_o + 6'h01;
        if (tc_minutes_o == `TCGJ_LAST_MIN) begin
          inc_m = 6'h00;
          inc_h = tc_hours_o + 5'h01;
          if (tc_hours_o == `TCGJ_LAST_HOUR) begin
            inc_h = 5'h00;                                            // [R21]
          end else if (tc_hours_o == `TCGJ_DST_HOUR && dst_start_pend) begin
            inc_h = `TCGJ_DST_SKIP_HOUR;                              // [R20]
            dst_start_hit = 1'b1;
          end else if (tc_hours_o == `TCGJ_DST_HOUR && dst_end_pend) begin
            inc_h = `TCGJ_DST_HOUR;                                   // [R18]
            dst_end_hit = 1'b1;
          end
        end
        if (drop_eff && (inc_m % `TCGJ_DROP_DECADE) != 6'h00) begin
          inc_f = `TCGJ_DROP_RESUME;                                  // [R1]
        end
      end
    end
  end

  // Conversion compares only frames once hours, minutes and seconds agree
  wire       hms_match;
  wire [4:0] frame_diff;
  wire       outside_window;

  assign hms_match  = (tgt_h == tc_hours_o) && (tgt_m == tc_minutes_o) &&
                      (tgt_s == tc_seconds_o);
  assign frame_diff = (tgt_f > tc_frames_o) ? (tgt_f - tc_frames_o) :
                                               (tc_frames_o - tgt_f);
  assign outside_window = !hms_match || (frame_diff > JAM_WINDOW);   // [R12]

  // Jam sequencer: capture target on one edge, apply it on the next
  reg jam_now;

  always @* begin
    next_state      = state;
    next_apply_full = apply_full;
    jam_now         = 1'b0;
    case (state)
      ST_IDLE: begin
        if (gen_mode_i == `TCGJ_MODE_MOMENT && jam_req_i && rdr_valid_i) begin
          next_state      = ST_APPLY;
          next_apply_full = 1'b1;
        end else if (gen_mode_i == `TCGJ_MODE_CONT && rdr_valid_i) begin
          next_state      = ST_APPLY;
          next_apply_full = 1'b1;
        end else if (gen_mode_i == `TCGJ_MODE_CONV && rdr_valid_i) begin
          next_state      = ST_APPLY;
          next_apply_full = 1'b0;
        end
      end
      ST_APPLY: begin
        next_state = ST_IDLE;
        jam_now    = apply_full || outside_window;                    // [R12]
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state      <= ST_IDLE;
      apply_full <= 1'b0;
      tgt_h      <= 5'h00;
      tgt_m      <= 6'h00;
      tgt_s      <= 6'h00;
      tgt_f      <= 5'h00;
    end else begin
      state      <= next_state;
      apply_full <= next_apply_full;
      if (state == ST_IDLE && next_state == ST_APPLY) begin
        tgt_h <= adj_h;
        tgt_m <= adj_m;
        tgt_s <= adj_s;
        tgt_f <= adj_f;
      end
    end
  end

  // Counter; a jam in the same cycle as a frame tick takes precedence
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tc_hours_o   <= 5'h00;
      tc_minutes_o <= 6'h00;
      tc_seconds_o <= 6'h00;
      tc_frames_o  <= 5'h00;
      jam_done_o   <= 1'b0;
      dst_repeat_o <= 1'b0;
    end else begin
      jam_done_o <= jam_now;
      if (jam_now) begin
        tc_hours_o   <= tgt_h;                                        // [R9] [R10]
        tc_minutes_o <= tgt_m;
        tc_seconds_o <= tgt_s;
        // Frame takes the target too: a full jam, or a conversion resync
        tc_frames_o  <= tgt_f;                                        // [R12]
      end else if (frame_tick_i) begin
        tc_hours_o   <= inc_h;                                        // [R9]
        tc_minutes_o <= inc_m;
        tc_seconds_o <= inc_s;
        tc_frames_o  <= inc_f;
        if (dst_end_hit) begin
          dst_repeat_o <= 1'b1;                                       // [R18]
        end else if (tc_hours_o == `TCGJ_DST_HOUR && inc_h != `TCGJ_DST_HOUR) begin
          dst_repeat_o <= 1'b0;
        end
      end
    end
  end

  // Arm requests stay pending until the transition uses them; set wins over use
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dst_start_pend <= 1'b0;
      dst_end_pend   <= 1'b0;
    end else begin
      dst_start_pend <= dst_start_arm_i |
                        (dst_start_pend & ~(frame_tick_i & ~jam_now & dst_start_hit));
      dst_end_pend   <= dst_end_arm_i |
                        (dst_end_pend & ~(frame_tick_i & ~jam_now & dst_end_hit));
    end
  end

  // Colour flag is set only in four-field mode with a locked reference;
  // counting never waits on the reference
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tc_drop_flag_o   <= 1'b0;
      tc_colour_flag_o <= 1'b0;
    end else begin
      tc_drop_flag_o   <= drop_eff;                                   // [R2]
      tc_colour_flag_o <= four_field_i & col_ref_lock_i;              // [R19]
    end
  end

  tcgj_vitc_keyer #(
    .LINE_W (LINE_W),
    .VID_W  (VID_W)
  ) u_keyer (
    .ref_clk_i               (ref_clk_i),
    .rst_i                   (rst_i),
    .std_625_i               (std_625_i),
    .vitc_on_i               (vitc_on_i),
    .smpte_insert_line_525_i (smpte_insert_line_525_i),
    .smpte_insert_line_625_i (smpte_insert_line_625_i),
    .irig_line_525_i         (irig_line_525_i),
    .irig_line_625_i         (irig_line_625_i),
    .vid_valid_i             (vid_valid_i),
    .vid_line_i              (vid_line_i),
    .vid_data_i              (vid_data_i),
    .vitc_smpte_data_i       (vitc_smpte_data_i),
    .vitc_irig_data_i        (vitc_irig_data_i),
    .vid_valid_o             (vid_valid_o),
    .vid_data_o              (vid_data_o)
  );

endmodule

// ### dv/tcgj_monitor.sv
`timescale 1ns/100ps
module tcgj_monitor #(
  parameter VID_W = 10
) (
  input wire             ref_clk_i,
  input wire             rst_i,
  input wire             frame_tick_i,
  input wire             std_625_i,
  input wire [1:0]       gen_mode_i,
  input wire             drop_sel_i,
  input wire             four_field_i,
  input wire             col_ref_lock_i,
  input wire             rdr_valid_i,
  input wire             rdr_drop_flag_i,
  input wire             rdr_irig_day_i,
  input wire             vitc_on_i,
  input wire             vid_valid_i,
  input wire [VID_W-1:0] vid_data_i,
  input wire [4:0]       tc_hours_o,
  input wire [5:0]       tc_minutes_o,
  input wire [5:0]       tc_seconds_o,
  input wire [4:0]       tc_frames_o,
  input wire             tc_drop_flag_o,
  input wire             tc_colour_flag_o,
  input wire             jam_done_o,
  input wire             vid_valid_o,
  input wire [VID_W-1:0] vid_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_drop_625 : assert property (std_625_i |=> !tc_drop_flag_o)
    else $error("drop flag set in 625");
  a_drop_cont : assert property (!std_625_i && gen_mode_i == 2'h2 |=>
    tc_drop_flag_o == $past(rdr_drop_flag_i | rdr_irig_day_i)) else $error("cont drop flag");
  a_drop_user : assert property (!std_625_i && gen_mode_i != 2'h2 |=>
    tc_drop_flag_o == $past(drop_sel_i)) else $error("user drop flag");
  a_drop_skip : assert property (frame_tick_i && tc_drop_flag_o && !$past(rdr_valid_i) &&
    tc_seconds_o == 6'h3b && tc_frames_o == 5'h1d && (tc_minutes_o + 7'h01) % 10 != 0
    |=> tc_frames_o == 5'h02 && tc_seconds_o == 6'h00) else $error("drop skip missed");
  a_frame_step : assert property (frame_tick_i && !$past(rdr_valid_i) && !$past(rst_i) &&
    tc_frames_o < 5'h18 |=> tc_frames_o == $past(tc_frames_o) + 5'h01)
    else $error("frame count step");
  a_day_wrap : assert property (frame_tick_i && !$past(rdr_valid_i) && tc_hours_o == 5'h17 &&
    tc_minutes_o == 6'h3b && tc_seconds_o == 6'h3b && tc_frames_o == (std_625_i ? 5'h18 : 5'h1d)
    |=> {tc_hours_o, tc_minutes_o, tc_seconds_o, tc_frames_o} == 22'h0) else $error("day wrap");
  a_jam_cause : assert property (jam_done_o |->
    $past(rdr_valid_i, 2) && $past(gen_mode_i, 2) != 2'h0) else $error("jam without word");
  a_jam_pulse : assert property (jam_done_o |=> !jam_done_o)
    else $error("jam done too long");
  a_colour_flag : assert property (1'b1 |=>
    tc_colour_flag_o == $past(four_field_i & col_ref_lock_i)) else $error("colour flag");
  a_video_pass : assert property (!vitc_on_i |=> vid_data_o == $past(vid_data_i))
    else $error("video altered while off");
  a_valid_delay : assert property (1'b1 |=> vid_valid_o == $past(vid_valid_i))
    else $error("video valid delay");
endmodule

// ### dv/tcgj_src_model.sv
`timescale 1ns/100ps
module tcgj_src_model (
  input  wire         ref_clk_i,
  input  wire         rst_i,
  input  wire         send_i,
  input  wire  [21:0] word_i,
  output logic        rdr_valid_o,
  output logic [21:0] rdr_word_o,
  output logic [9:0]  vid_line_o,
  output logic [9:0]  vid_data_o,
  output logic [9:0]  smpte_data_o,
  output logic [9:0]  irig_data_o,
  output logic        vid_valid_o
);
  // Outside the valid slot the word shows its own inverse, so a late latch reads junk
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdr_valid_o <= 1'b0;
      rdr_word_o  <= 22'h0;
      vid_line_o  <= 10'h000;
      vid_data_o  <= 10'h000;
    end else begin
      rdr_valid_o <= send_i;
      rdr_word_o  <= send_i ? word_i : ~rdr_word_o;
      vid_line_o  <= (vid_line_o == 10'h027) ? 10'h000 : vid_line_o + 10'h001;
      vid_data_o  <= vid_data_o + 10'h035;
    end
  end
  assign smpte_data_o = ~vid_data_o;
  assign irig_data_o  = vid_data_o ^ 10'h2aa;
  assign vid_valid_o  = vid_line_o[1];
endmodule

// ### dv/tcgj_timecode_jam_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tcgj_timecode_jam_tb_top;
  logic        ref_clk_i, rst_i, frame_tick_i, std_625_i, drop_sel_i, four_field_i, send;
  logic        col_ref_lock_i, jam_req_i, rdr_drop_flag_i, rdr_irig_day_i, vitc_on_i;
  logic        dst_start_arm_i, dst_end_arm_i;
  logic [1:0]  gen_mode_i, ok;
  logic [9:0]  smpte_insert_line_525_i, smpte_insert_line_625_i, exp_vid;
  logic [9:0]  irig_line_525_i, irig_line_625_i;
  logic [21:0] off, word;
  logic [68:0] rows [8];
  int          failures, total_checks, cycles;
  wire         rdr_valid_i, vid_valid_i, tc_drop_flag_o, tc_colour_flag_o, jam_done_o;
  wire         dst_repeat_o, vid_valid_o;
  wire  [4:0]  rdr_hours_i, rdr_frames_i, jam_offset_value_hours_i, jam_offset_value_frames_i;
  wire  [5:0]  rdr_minutes_i, rdr_seconds_i, jam_offset_value_minutes_i;
  wire  [5:0]  jam_offset_value_seconds_i, tc_minutes_o, tc_seconds_o;
  wire  [4:0]  tc_hours_o, tc_frames_o;
  wire  [9:0]  vid_line_i, vid_data_i, vitc_smpte_data_i, vitc_irig_data_i, vid_data_o;
  wire  [21:0] rword;
  wire  [21:0] tc = {tc_hours_o, tc_minutes_o, tc_seconds_o, tc_frames_o};

  assign {rdr_hours_i, rdr_minutes_i, rdr_seconds_i, rdr_frames_i} = rword;
  assign {jam_offset_value_hours_i, jam_offset_value_minutes_i} = off[21:11];
  assign {jam_offset_value_seconds_i, jam_offset_value_frames_i} = off[10:0];

  tcgj_timecode_jam tcgj_timecode_jam_i (.*);
  tcgj_src_model tcgj_src_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .send_i(send),
    .word_i(word), .rdr_valid_o(rdr_valid_i), .rdr_word_o(rword), .vid_line_o(vid_line_i),
    .vid_data_o(vid_data_i), .smpte_data_o(vitc_smpte_data_i), .irig_data_o(vitc_irig_data_i),
    .vid_valid_o(vid_valid_i));

  function automatic logic [21:0] t(input int h, input int m, input int s, input int f);
    return {h[4:0], m[5:0], s[5:0], f[4:0]};
  endfunction

  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Word goes out through the reader model, so it is valid one cycle after send
  task automatic jam(input logic [1:0] m, input logic [21:0] o, input logic [21:0] w);
    @(posedge ref_clk_i) #1;
    gen_mode_i = m;
    off = o;
    word = w;
    send = 1'b1;
    @(posedge ref_clk_i) #1;
    send = 1'b0;
    jam_req_i = 1'b1;
    @(posedge ref_clk_i) #1;
    jam_req_i = 1'b0;
    @(posedge ref_clk_i) #1;
  endtask

  task automatic tick;
    @(posedge ref_clk_i) #1;
    frame_tick_i = 1'b1;
    @(posedge ref_clk_i) #1;
    frame_tick_i = 1'b0;
  endtask

  task automatic pulse_arm(input logic start);
    dst_start_arm_i = start;
    dst_end_arm_i = !start;
    @(posedge ref_clk_i) #1;
    {dst_start_arm_i, dst_end_arm_i} = 2'h0;
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Expected video is rebuilt from the inputs of the previous edge
  always @(posedge ref_clk_i) begin
    ok <= {ok[0], !rst_i};
    exp_vid <= !vitc_on_i ? vid_data_i :
      vid_line_i == (std_625_i ? smpte_insert_line_625_i : smpte_insert_line_525_i) ?
      vitc_smpte_data_i : vid_line_i == (std_625_i ? irig_line_625_i : irig_line_525_i) ?
      vitc_irig_data_i : vid_data_i;
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      print_verdict;
    end
  end
  always @(negedge ref_clk_i) if (ok[1] && !rst_i) `CHK(vid_data_o, exp_vid)

  initial begin
    {frame_tick_i, std_625_i, four_field_i, col_ref_lock_i, jam_req_i, send} = 6'h00;
    {rdr_irig_day_i, dst_start_arm_i, dst_end_arm_i, vitc_on_i} = 4'h0;
    drop_sel_i = 1'b1;
    rdr_drop_flag_i = 1'b1;
    gen_mode_i = 2'h0;
    {off, word, failures, total_checks} = '0;
    {smpte_insert_line_525_i, irig_line_525_i} = {10'h00a, 10'h00c};
    {smpte_insert_line_625_i, irig_line_625_i} = {10'h007, 10'h009};
    rst_i = 1'b1;
    rows[0] = {1'b1, 2'h1, t(0, 0, 0, 0), t(1, 0, 0, 0), t(1, 0, 0, 0)};
    rows[1] = {1'b1, 2'h2, t(0, 0, 1, 0), t(1, 0, 0, 0), t(1, 0, 1, 0)};
    rows[2] = {1'b1, 2'h2, t(23, 59, 59, 0), t(1, 0, 0, 0), t(0, 59, 59, 0)};
    rows[3] = {1'b0, 2'h3, t(0, 0, 0, 0), t(0, 59, 59, 6), t(0, 59, 59, 0)};
    rows[4] = {1'b1, 2'h3, t(0, 0, 0, 0), t(0, 59, 59, 7), t(0, 59, 59, 7)};
    rows[5] = {1'b1, 2'h3, t(0, 0, 0, 0), t(0, 59, 58, 7), t(0, 59, 58, 7)};
    rows[6] = {1'b0, 2'h0, t(0, 0, 0, 0), t(5, 0, 0, 0), t(0, 59, 58, 7)};
    rows[7] = {1'b1, 2'h2, t(0, 0, 0, 5), t(0, 0, 0, 27), t(0, 0, 1, 2)};
    repeat (8) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      jam(rows[i][67:66], rows[i][65:44], rows[i][43:22]);
      `CHK(tc, rows[i][21:0])
      `CHK(jam_done_o, rows[i][68])
    end
    `CHK(tc_colour_flag_o, 1'b0)
    {vitc_on_i, four_field_i, col_ref_lock_i} = 3'h7;
    jam(2'h2, 22'h0, t(0, 0, 59, 29));
    `CHK(tc_colour_flag_o, 1'b1)
    tick;
    `CHK(tc, t(0, 1, 0, 2))
    `CHK(tc_drop_flag_o, 1'b1)
    jam(2'h2, 22'h0, t(0, 9, 59, 29));
    tick;
    `CHK(tc, t(0, 10, 0, 0))
    rdr_drop_flag_i = 1'b0;
    jam(2'h2, 22'h0, t(0, 0, 59, 29));
    tick;
    `CHK(tc, t(0, 1, 0, 0))
    `CHK(tc_drop_flag_o, 1'b0)
    rdr_irig_day_i = 1'b1;
    @(posedge ref_clk_i) #1;
    `CHK(tc_drop_flag_o, 1'b1)
    std_625_i = 1'b1;
    jam(2'h1, 22'h0, t(0, 0, 59, 24));
    tick;
    `CHK(tc, t(0, 1, 0, 0))
    `CHK(tc_drop_flag_o, 1'b0)
    repeat (40) @(posedge ref_clk_i);
    #1 std_625_i = 1'b0;
    drop_sel_i = 1'b0;
    jam(2'h1, 22'h0, t(23, 59, 59, 29));
    tick;
    `CHK(tc, t(0, 0, 0, 0))
    jam(2'h1, 22'h0, t(1, 59, 59, 29));
    pulse_arm(1'b1);
    tick;
    `CHK(tc, t(3, 0, 0, 0))
    jam(2'h1, 22'h0, t(1, 59, 59, 29));
    pulse_arm(1'b0);
    tick;
    `CHK(tc, t(1, 0, 0, 0))
    `CHK(dst_repeat_o, 1'b1)
    jam(2'h1, 22'h0, t(1, 59, 59, 29));
    tick;
    `CHK(tc, t(2, 0, 0, 0))
    `CHK(dst_repeat_o, 1'b0)
    drop_sel_i = 1'b1;
    jam(2'h1, 22'h0, t(0, 0, 59, 29));
    tick;
    `CHK(tc, t(0, 1, 0, 2))
    `CHK(tc_drop_flag_o, 1'b1)
    rst_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK(tc, 22'h0)
    rst_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    print_verdict;
  end
endmodule

bind tcgj_timecode_jam tcgj_monitor #(.VID_W(VID_W)) tcgj_monitor_i (.*);
